/* rtl/mpf_mac_regs.sv */
// MAC management, pause and address filter registers on APB
`timescale 1ns/1ns
module mpf_mac_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mpf_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Datapath events and pause load
  input wire logic [mpf_pkg::EVT_W-1:0] dp_evt_i,
  input wire logic pause_load_i,
  input wire logic [15:0] pause_value_i,
  output logic pausing_o,
  // Receive address filter
  input wire logic rx_da_valid_i,
  input wire logic [47:0] rx_da_i,
  output logic da_match_o,
  output logic [63:0] hash_filter_o,
  // Management pins
  output logic mdc_o,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Interrupt
  output logic irq_o
);
  import mpf_pkg::*;

  // Bus phase decode
  logic setup, acc, wr, rd;
  logic [31:0] nxt_prdata, prdata_ff;
  logic nxt_pready, pready_ff, nxt_pslverr, pslverr_ff;
  logic hit;

  // Interrupt state
  logic [13:0] status_ff, nxt_status, mask_ff, nxt_mask, evt;
  logic irq_ff, nxt_irq;

  // Management register
  mpf_mgmt_frame_s mgmt_ff, nxt_mgmt;
  logic go_ff, nxt_go;
  logic sh_busy, sh_done;
  logic [15:0] sh_rdata;

  // Pause counter
  logic [15:0] pause_ff, nxt_pause;
  logic [9:0] tick_ff, nxt_tick;
  logic pausing_ff, nxt_pausing, pause_time_zero;

  // Filter registers
  logic [31:0] hash_lo_ff, nxt_hash_lo, hash_hi_ff, nxt_hash_hi;
  mpf_match_addr_s [MATCH_NUM-1:0] match_ff, nxt_match;
  logic [MATCH_NUM-1:0] hit_vec;
  logic match_ff_o, nxt_match_o;
  logic [63:0] hash_out_ff;

  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i & pready_ff & ~pslverr_ff;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;

  // Read mux, registered at the setup edge so data is ready in access
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr_i)
      OFS_IRQ_STATUS: nxt_prdata = {18'h0, status_ff};
      OFS_IRQ_ENABLE: nxt_prdata = 32'h0000_0000;
      OFS_IRQ_DISABLE: nxt_prdata = 32'h0000_0000;
      OFS_IRQ_MASK_STATUS: nxt_prdata = {18'h0, mask_ff};
      OFS_IRQ_CLEAR: nxt_prdata = 32'h0000_0000;
      OFS_PHY_MGMT_FRAME: nxt_prdata = mgmt_ff;
      OFS_PAUSE_COUNT: nxt_prdata = {16'h0, pause_ff};
      OFS_MGMT_STATE: nxt_prdata = {31'h0, ~(sh_busy | go_ff)};
      OFS_HASH_LOW: nxt_prdata = hash_lo_ff;
      OFS_HASH_HIGH: nxt_prdata = hash_hi_ff;
      default:
      begin
        hit = 1'b0;
        for (int i = 0; i < MATCH_NUM; i++)
        begin
          if (paddr_i == OFS_MATCH_BASE + 8'(8 * i))
          begin
            nxt_prdata = match_ff[i].low;
            hit = 1'b1;
          end
          if (i < MATCH_NUM - 1 && paddr_i == OFS_MATCH_BASE + 8'(8 * i + 4))
          begin
            nxt_prdata = {16'h0, match_ff[i].high};
            hit = 1'b1;
          end
        end
      end
    endcase
    nxt_pready = setup;
    nxt_pslverr = setup & ~hit;
    if (!setup)
      nxt_prdata = prdata_ff;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Interrupt status, mask and line
  always_comb
  begin
    evt = (dp_evt_i & EVT_FROM_DP);
    evt[EVT_MGMT_DONE] = sh_done;
    evt[EVT_PAUSE_TIME_ZERO] = pause_time_zero;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    // Read clears only the bits returned, so a fresh event is never lost
    if (rd && paddr_i == OFS_IRQ_STATUS)
      nxt_status = status_ff & ~prdata_ff[13:0];
    if (wr && paddr_i == OFS_IRQ_CLEAR)
      nxt_status = nxt_status & ~pwdata_i[13:0];
    nxt_status = (nxt_status | evt) & EVT_VALID;
    if (wr && paddr_i == OFS_IRQ_ENABLE)
      nxt_mask = mask_ff & ~pwdata_i[13:0];
    if (wr && paddr_i == OFS_IRQ_DISABLE)
      nxt_mask = (mask_ff | pwdata_i[13:0]) & EVT_VALID;
    nxt_irq = |(nxt_status & ~nxt_mask);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      status_ff <= 14'h0000;
      mask_ff <= IRQ_MASK_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  // Management frame register and launch
  always_comb
  begin
    nxt_mgmt = mgmt_ff;
    nxt_go = 1'b0;
    // Writes while a frame is in flight are dropped
    if (wr && paddr_i == OFS_PHY_MGMT_FRAME && !(sh_busy || go_ff))
    begin
      nxt_mgmt = pwdata_i;
      // Bad start or operation codes never reach the pins
      nxt_go = (pwdata_i[31:30] == MGMT_SOF) &&
               (pwdata_i[29:28] == MGMT_OP_READ ||
                pwdata_i[29:28] == MGMT_OP_WRITE);
    end
    if (sh_done && mgmt_ff.op == MGMT_OP_READ)
      nxt_mgmt.data = sh_rdata;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mgmt_ff <= MGMT_FRAME_RST;
      go_ff <= 1'b0;
    end
    else
    begin
      mgmt_ff <= nxt_mgmt;
      go_ff <= nxt_go;
    end
  end

  mpf_mgmt_shift u_shift (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(go_ff),
    .frame_i(mgmt_ff),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .rd_data_o(sh_rdata),
    .mdc_o(mdc_o),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o)
  );

  // Pause counter, one step per 512 bit times while non-zero
  always_comb
  begin
    nxt_pause = pause_ff;
    nxt_tick = tick_ff;
    pause_time_zero = 1'b0;
    if (pause_ff != 16'h0000)
    begin
      nxt_tick = tick_ff + 10'h001;
      if (tick_ff == 10'(PAUSE_TICK_CYC - 1))
      begin
        nxt_tick = 10'h000;
        nxt_pause = pause_ff - 16'h0001;
        pause_time_zero = (pause_ff == 16'h0001);
      end
    end
    if (pause_load_i)
    begin
      nxt_pause = pause_value_i;
      nxt_tick = 10'h000;
    end
    if (wr && paddr_i == OFS_PAUSE_COUNT)
    begin
      nxt_pause = pwdata_i[15:0];
      nxt_tick = 10'h000;
    end
    nxt_pausing = (nxt_pause != 16'h0000);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pause_ff <= PAUSE_RST;
      tick_ff <= 10'h000;
      pausing_ff <= 1'b0;
    end
    else
    begin
      pause_ff <= nxt_pause;
      tick_ff <= nxt_tick;
      pausing_ff <= nxt_pausing;
    end
  end

  // Hash and specific address registers
  always_comb
  begin
    nxt_hash_lo = hash_lo_ff;
    nxt_hash_hi = hash_hi_ff;
    nxt_match = match_ff;
    if (wr && paddr_i == OFS_HASH_LOW)
      nxt_hash_lo = pwdata_i;
    if (wr && paddr_i == OFS_HASH_HIGH)
      nxt_hash_hi = pwdata_i;
    for (int i = 0; i < MATCH_NUM; i++)
    begin
      if (wr && paddr_i == OFS_MATCH_BASE + 8'(8 * i))
        nxt_match[i].low = pwdata_i;
      if (wr && i < MATCH_NUM - 1 &&
          paddr_i == OFS_MATCH_BASE + 8'(8 * i + 4))
        nxt_match[i].high = pwdata_i[15:0];
    end
    nxt_match_o = rx_da_valid_i & (|hit_vec);
  end

  // Bit 0 of each entry meets bit 0 of the first received byte
  for (genvar g = 0; g < MATCH_NUM; g++)
  begin : g_match
    assign hit_vec[g] = (rx_da_i == {match_ff[g].high, match_ff[g].low});
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hash_lo_ff <= ADDR_RST;
      hash_hi_ff <= ADDR_RST;
      match_ff <= '0;
      match_ff_o <= 1'b0;
      hash_out_ff <= 64'h0;
    end
    else
    begin
      hash_lo_ff <= nxt_hash_lo;
      hash_hi_ff <= nxt_hash_hi;
      match_ff <= nxt_match;
      match_ff_o <= nxt_match_o;
      hash_out_ff <= {nxt_hash_hi, nxt_hash_lo};
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o = irq_ff;
  assign pausing_o = pausing_ff;
  assign da_match_o = match_ff_o;
  assign hash_filter_o = hash_out_ff;

endmodule // mpf_mac_regs

/* rtl/mpf_mgmt_shift.sv */
// Serial management frame shifter toward the PHY
`timescale 1ns/1ns
module mpf_mgmt_shift (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Frame request
  input wire logic start_i,
  input wire mpf_pkg::mpf_mgmt_frame_s frame_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rd_data_o,
  // Management pins
  output logic mdc_o,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o
);
  import mpf_pkg::*;

  mpf_mgmt_state_e state_ff, nxt_state;
  logic [31:0] word_ff, nxt_word;
  logic [5:0] bit_ff, nxt_bit;
  logic [4:0] div_ff, nxt_div;
  logic mdc_ff, nxt_mdc, out_ff, nxt_out, oe_ff, nxt_oe, done_ff, nxt_done;
  logic rd_ff, nxt_rd;
  logic [15:0] rdat_ff, nxt_rdat;
  logic sync1_ff, sync2_ff;
  logic [5:0] nb;

  // Pin input synchroniser
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= mdio_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_word = word_ff;
    nxt_bit = bit_ff;
    nxt_div = div_ff;
    nxt_mdc = mdc_ff;
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    nxt_done = 1'b0;
    nxt_rd = rd_ff;
    nxt_rdat = rdat_ff;
    nb = bit_ff + 6'h01;
    unique case (state_ff)
      MPF_IDLE:
      begin
        if (start_i)
        begin
          nxt_state = MPF_SHIFT;
          nxt_word = frame_i;
          nxt_rd = (frame_i.op == MGMT_OP_READ);
          nxt_bit = 6'h00;
          nxt_div = 5'h00;
          nxt_mdc = 1'b0;
          nxt_out = 1'b1;
          nxt_oe = 1'b1;
        end
      end
      MPF_SHIFT:
      begin
        nxt_div = div_ff + 5'h01;
        if (div_ff == 5'(MDC_HALF_CYC - 1))
        begin
          nxt_div = 5'h00;
          nxt_mdc = ~mdc_ff;
          if (!mdc_ff)
          begin
            if (rd_ff && bit_ff >= 6'(MGMT_SAMPLE_BIT))
              nxt_rdat = {rdat_ff[14:0], sync2_ff};
          end
          else if (bit_ff == 6'(MGMT_BITS - 1))
          begin
            nxt_state = MPF_IDLE;
            nxt_done = 1'b1;
            nxt_oe = 1'b0;
            nxt_out = 1'b0;
          end
          else
          begin
            nxt_bit = nb;
            // Preamble of ones, then the frame word from its top bit
            nxt_out = (nb < 6'(MGMT_PREAMBLE)) ? 1'b1 : word_ff[~nb[4:0]];
            nxt_oe = ~(rd_ff && nb >= 6'(MGMT_RELEASE_BIT));
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= MPF_IDLE;
      word_ff <= MGMT_FRAME_RST;
      bit_ff <= 6'h00;
      div_ff <= 5'h00;
      mdc_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      done_ff <= 1'b0;
      rd_ff <= 1'b0;
      rdat_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      word_ff <= nxt_word;
      bit_ff <= nxt_bit;
      div_ff <= nxt_div;
      mdc_ff <= nxt_mdc;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      done_ff <= nxt_done;
      rd_ff <= nxt_rd;
      rdat_ff <= nxt_rdat;
    end
  end

  assign busy_o = (state_ff == MPF_SHIFT);
  assign done_o = done_ff;
  assign rd_data_o = rdat_ff;
  assign mdc_o = mdc_ff;
  assign mdio_o = out_ff;
  assign mdio_oe_o = oe_ff;

endmodule // mpf_mgmt_shift

/* rtl/mpf_pkg.sv */
// Package of constants and types for the MAC management and filter registers
// Behaviour
// - Mask view shows masked state per source
// - Read result lands in management data field
// - Code field written 10, reads back
// - Operation 10 reads, 01 writes, else invalid
// - Frame carries PHY and register selects
// - Pause count decrements every 512 bit times
// - Hash low holds filter bits 31:0
// - Hash high holds filter bits 63:32
// - Match low holds address low 32 bits
// - Bit zero compares first byte LSB
// - Enable unmasks, disable masks, view follows
// - Pause zero flag sets, clears on read
package mpf_pkg;

  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_PHY_MGMT_FRAME = 8'h14;
  localparam logic [7:0] OFS_PAUSE_COUNT = 8'h18;
  localparam logic [7:0] OFS_MGMT_STATE = 8'h1C;
  localparam logic [7:0] OFS_HASH_LOW = 8'h20;
  localparam logic [7:0] OFS_HASH_HIGH = 8'h24;
  localparam logic [7:0] OFS_MATCH_BASE = 8'h28;
  localparam int MATCH_NUM = 4;

  // Event bit positions
  localparam int EVT_W = 14;
  localparam int EVT_MGMT_DONE = 0;
  localparam int EVT_PAUSE_TIME_ZERO = 13;
  localparam logic [13:0] EVT_VALID = 14'h3CFF;
  localparam logic [13:0] EVT_FROM_DP = 14'h1CFE;
  localparam logic [13:0] IRQ_MASK_RST = 14'h3CFF;

  // Management frame encodings
  localparam logic [1:0] MGMT_SOF = 2'h1;
  localparam logic [1:0] MGMT_OP_READ = 2'h2;
  localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
  localparam logic [1:0] MGMT_CODE = 2'h2;
  localparam logic [31:0] MGMT_FRAME_RST = 32'h0000_0000;
  localparam int MGMT_PREAMBLE = 32;
  localparam int MGMT_BITS = 64;
  localparam int MGMT_RELEASE_BIT = 46;
  localparam int MGMT_SAMPLE_BIT = 48;

  // Timing
  localparam int CLK_NS = 10;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = MDC_HALF_NS / CLK_NS;
  localparam int BIT_TIME_NS = 10;
  localparam int PAUSE_QUANTUM_BITS = 512;
  localparam int PAUSE_TICK_CYC = PAUSE_QUANTUM_BITS * BIT_TIME_NS / CLK_NS;

  localparam logic [15:0] PAUSE_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] start;
    logic [1:0] op;
    logic [4:0] phy_select;
    logic [4:0] phy_reg_select;
    logic [1:0] code;
    logic [15:0] data;
  } mpf_mgmt_frame_s;

  typedef struct packed {
    logic [15:0] high;
    logic [31:0] low;
  } mpf_match_addr_s;

  typedef enum logic {MPF_IDLE, MPF_SHIFT} mpf_mgmt_state_e;

endpackage

/* sim/mpf_mac_regs_monitor.sv */
// Assertion checker bound to the MAC register block
`timescale 1ns/1ns
module mpf_mac_regs_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mpf_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Datapath and filter
  input wire logic [mpf_pkg::EVT_W-1:0] dp_evt_i,
  input wire logic pause_load_i,
  input wire logic [15:0] pause_value_i,
  input wire logic pausing_o,
  input wire logic rx_da_valid_i,
  input wire logic [47:0] rx_da_i,
  input wire logic da_match_o,
  input wire logic [63:0] hash_filter_o,
  // Management and interrupt
  input wire logic mdc_o,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic irq_o
);
  import mpf_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic acc_w;
  logic mg_w;
  logic hash_w;
  logic ok_op;
  logic [7:0] idle_ff;
  logic en_ff;
  assign acc_w = psel_i && penable_i && pready_o && pwrite_i;
  assign mg_w = acc_w && paddr_i == OFS_PHY_MGMT_FRAME && idle_ff > 8'd60;
  assign hash_w = acc_w && paddr_i[7:3] == 5'h04;
  assign ok_op = pwdata_i[29:28] == MGMT_OP_READ
    || pwdata_i[29:28] == MGMT_OP_WRITE;
  // Counts quiet cycles on the management pins
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      idle_ff <= 8'h00;
    else if (mdc_o || mdio_oe_o)
      idle_ff <= 8'h00;
    else if (idle_ff != 8'hFF)
      idle_ff <= idle_ff + 8'h01;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      en_ff <= 1'b0;
    else if (acc_w && paddr_i == OFS_IRQ_ENABLE && pwdata_i != 32'h0)
      en_ff <= 1'b1;
  chk_apb_zero_wait: assert property (psel_i && !penable_i |=> pready_o
    ##1 !pready_o) else $error("pready not one cycle after setup");
  chk_unmapped_err: assert property (psel_i && !penable_i
    && paddr_i > 8'h40 |=> pslverr_o) else $error("no error on unmapped");
  chk_pause_load: assert property (pause_load_i |=> pausing_o
    == ($past(pause_value_i) != 16'h0)) else $error("pausing after load");
  chk_match_cause: assert property (da_match_o |-> $past(rx_da_valid_i))
    else $error("match without address");
  chk_hash_update: assert property ($changed(hash_filter_o)
    |-> $past(hash_w) || $past(hash_w, 2)) else $error("hash changed alone");
  chk_mdc_high: assert property ($rose(mdc_o) |=> mdc_o [*8])
    else $error("mdc high phase short");
  chk_mdc_low: assert property ($fell(mdc_o) |=> !mdc_o [*8])
    else $error("mdc low phase short");
  chk_frame_launch: assert property (mg_w && ok_op
    && pwdata_i[31:30] == MGMT_SOF |-> ##[1:4] mdio_oe_o)
    else $error("valid frame not launched");
  chk_bad_op_quiet: assert property (mg_w && !ok_op
    |=> !mdio_oe_o [*8]) else $error("invalid frame launched");
  chk_irq_masked: assert property (irq_o |-> en_ff)
    else $error("irq while all masked");
  cover property (mg_w);
  cover property ($rose(irq_o));
  cover property (da_match_o);
  cover property ($fell(pausing_o));
endmodule // mpf_mac_regs_monitor

bind mpf_mac_regs mpf_mac_regs_monitor u_mon (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .dp_evt_i(dp_evt_i), .pause_load_i(pause_load_i),
  .pause_value_i(pause_value_i), .pausing_o(pausing_o),
  .rx_da_valid_i(rx_da_valid_i), .rx_da_i(rx_da_i),
  .da_match_o(da_match_o), .hash_filter_o(hash_filter_o), .mdc_o(mdc_o),
  .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));

/* sim/mpf_phy_model.sv */
// Behavioural PHY answering management frames
`timescale 1ns/1ns
module mpf_phy_model #(
  parameter logic [15:0] RD_VAL = 16'hA5C3
) (
  // Reset
  input wire logic reset_n_i,
  // Management pins of the block
  input wire logic mdc_i,
  input wire logic mst_d_i,
  input wire logic mst_oe_i,
  // Resolved line and captured frame
  output logic line_o,
  output logic [63:0] cap_o
);
  logic [5:0] pos_ff;
  logic drv_ff;
  logic dat_ff;
  // Released line is pulled up
  assign line_o = mst_oe_i ? mst_d_i : (drv_ff ? dat_ff : 1'b1);
  always @(posedge mdc_i or negedge reset_n_i)
    if (!reset_n_i)
      pos_ff <= 6'h00;
    else
      pos_ff <= pos_ff + 6'h01;
  always @(posedge mdc_i)
    cap_o <= {cap_o[62:0], line_o};
  // Answer only read frames, from the second turnaround bit on
  always @(negedge mdc_i or negedge reset_n_i)
    if (!reset_n_i)
      drv_ff <= 1'b0;
    else
      drv_ff <= pos_ff >= 6'd47 && (pos_ff == 6'd47 ? cap_o[12:11] == 2'b10
        : drv_ff);
  always @(negedge mdc_i)
    dat_ff <= pos_ff == 6'd47 ? 1'b0 : RD_VAL[4'(6'd63 - pos_ff)];
endmodule // mpf_phy_model

/* sim/test_mac_phy_mgmt_and_addr_filter_regs.sv */
// Self-checking testbench for the MAC register block
`timescale 1ns/1ns
module test_mac_phy_mgmt_and_addr_filter_regs;
  import mpf_pkg::*;
  localparam logic [15:0] RD_VAL = 16'h5A3C;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, rerr;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, rdat, prdata_o;
  logic [13:0] dp_evt_i = 14'h0;
  logic pause_load_i = 1'b0, rx_da_valid_i = 1'b0;
  logic [15:0] pause_value_i = 16'h0;
  logic [47:0] rx_da_i = 48'h0;
  logic pready_o, pslverr_o, pausing_o, da_match_o, mdc_o, mdio_o;
  logic mdio_oe_o, irq_o, mdio_i;
  logic [63:0] hash_filter_o, cap;
  int num_errors = 0, checks_done = 0;
  always #5 clk_i = ~clk_i;
  mpf_mac_regs dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .dp_evt_i(dp_evt_i), .pause_load_i(pause_load_i),
    .pause_value_i(pause_value_i), .pausing_o(pausing_o),
    .rx_da_valid_i(rx_da_valid_i), .rx_da_i(rx_da_i),
    .da_match_o(da_match_o), .hash_filter_o(hash_filter_o), .mdc_o(mdc_o),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));
  mpf_phy_model #(.RD_VAL(RD_VAL)) phy (.reset_n_i(reset_n_i),
    .mdc_i(mdc_o), .mst_d_i(mdio_o), .mst_oe_i(mdio_oe_o),
    .line_o(mdio_i), .cap_o(cap));
  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Answer is taken at the rising edge that samples pready high
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Let the access edge settle before callers look at outputs
    @(negedge clk_i);
  endtask
  function automatic logic [31:0] pat(input int i);
    return 32'hC3A5_0F01 + 32'(i) * 32'h1357_9BDF;
  endfunction
  task t_regs;
    logic [7:0] a;
    for (int i = 0; i < 9; i++)
    begin
      a = OFS_HASH_LOW + 8'(4 * i);
      apb(0, a, 0);
      chk("reset value", rdat, 0);
      apb(1, a, pat(i));
      apb(0, a, 0);
      chk("readback", rdat, (i > 2 && i % 2 == 1) ? pat(i) & 32'hFFFF : pat(i));
    end
    chk("hash out", hash_filter_o, {pat(1), pat(0)});
    apb(0, OFS_PAUSE_COUNT, 0);
    chk("pause reset", rdat, 0);
    apb(0, 8'h80, 0);
    chk("unmapped", rerr, 1);
  endtask
  task t_mask;
    apb(1, OFS_IRQ_MASK_STATUS, 0);
    apb(0, OFS_IRQ_MASK_STATUS, 0);
    chk("mask reset", rdat, 32'h3CFF);
    apb(1, OFS_IRQ_ENABLE, 32'h3CFF);
    apb(0, OFS_IRQ_MASK_STATUS, 0);
    chk("unmask all", rdat, 0);
    apb(1, OFS_IRQ_DISABLE, 32'h3CFF);
    apb(0, OFS_IRQ_MASK_STATUS, 0);
    chk("mask all", rdat, 32'h3CFF);
  endtask
  task ev;
    @(posedge clk_i);
    dp_evt_i <= 14'h0002;
    @(posedge clk_i);
    dp_evt_i <= 14'h0;
    @(negedge clk_i);
  endtask
  task t_irq;
    apb(1, OFS_IRQ_ENABLE, 32'h2);
    ev;
    chk("irq on", irq_o, 1);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("status", rdat, 32'h2);
    chk("irq after read", irq_o, 0);
    apb(1, OFS_IRQ_DISABLE, 32'h2);
    ev;
    chk("irq masked", irq_o, 0);
    apb(1, OFS_IRQ_CLEAR, 32'h2);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("status cleared", rdat, 0);
  endtask
  task mgmt(input logic [31:0] w);
    apb(1, OFS_PHY_MGMT_FRAME, w);
    repeat (4) @(posedge clk_i);
    rdat = 0;
    for (int k = 0; k < 2000 && rdat[0] !== 1'b1; k++)
      apb(0, OFS_MGMT_STATE, 0);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("mgmt done", rdat[0], 1);
  endtask
  task t_mgmt;
    logic [31:0] w;
    w = {MGMT_SOF, MGMT_OP_WRITE, 5'h0A, 5'h13, MGMT_CODE, 16'hBEEF};
    mgmt(w);
    chk("wire word", cap[31:0], w);
    apb(0, OFS_PHY_MGMT_FRAME, 0);
    chk("frame back", rdat, w);
    w = {MGMT_SOF, MGMT_OP_READ, 5'h15, 5'h0C, MGMT_CODE, 16'h0};
    mgmt(w);
    chk("read head", cap[31:18], w[31:18]);
    apb(0, OFS_PHY_MGMT_FRAME, 0);
    chk("read data", rdat, {w[31:16], RD_VAL});
  endtask
  task t_bad;
    logic [31:0] w;
    for (int k = 0; k < 3; k++)
    begin
      w = {k == 2 ? 2'b00 : MGMT_SOF,
           k == 0 ? 2'b00 : (k == 1 ? 2'b11 : MGMT_OP_READ), 28'h0A4_0123};
      apb(1, OFS_PHY_MGMT_FRAME, w);
      repeat (100) @(posedge clk_i);
      chk("no frame", {mdio_oe_o, mdc_o}, 0);
      apb(0, OFS_IRQ_STATUS, 0);
      chk("no done", rdat[0], 0);
    end
  endtask
  task t_pause;
    apb(0, OFS_IRQ_STATUS, 0);
    @(posedge clk_i);
    pause_load_i <= 1'b1;
    pause_value_i <= 16'h0003;
    @(posedge clk_i);
    pause_load_i <= 1'b0;
    apb(0, OFS_PAUSE_COUNT, 0);
    chk("pause loaded", {pausing_o, rdat}, {1'b1, 32'h3});
    repeat (600) @(posedge clk_i);
    apb(0, OFS_PAUSE_COUNT, 0);
    chk("pause step", rdat, 32'h2);
    repeat (1100) @(posedge clk_i);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("pause zero", {pausing_o, rdat[13]}, 2'b01);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("zero cleared", rdat[13], 0);
  endtask
  task t_filter;
    logic [47:0] v[3];
    v = '{48'h5544_3322_1101, 48'h5544_3322_1100, 48'h5545_3322_1101};
    apb(1, OFS_MATCH_BASE + 8'h08, 32'h3322_1101);
    apb(1, OFS_MATCH_BASE + 8'h0C, 32'h5544);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      rx_da_valid_i <= 1'b1;
      rx_da_i <= v[k];
      @(posedge clk_i);
      rx_da_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("match", da_match_o, k == 0);
    end
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs;
    $display("test regs done");
    t_mask;
    $display("test mask done");
    t_irq;
    $display("test irq done");
    t_mgmt;
    $display("test mgmt done");
    t_bad;
    $display("test bad frame done");
    t_pause;
    $display("test pause done");
    t_filter;
    $display("test filter done");
    finish_test;
  end
endmodule // test_mac_phy_mgmt_and_addr_filter_regs
